// [radio_seq_pkg.sv]
// shared constants and types for the radio mode sequencer and its host driver
// ============================================================
// Contract
// - wake from sleep lands in idle only
// - oscillator start, then host interface powers up
// - host wakes synthesizer before transmit or receive
// - host calibrates after power-off or long idle
// - host loads whole frame before transmit
// - transmit sends frame, then returns to idle
// - receive returns to idle after one frame
// - host awaits acknowledge, retransmits on timeout
// - next frame on acknowledge; sleep after last
package radio_seq_pkg;
  // ============================================================
  // timing
  localparam int CLK_PERIOD_NS    = 100;
  localparam int XOSC_START_US    = 250;
  localparam int XOSC_START_CYC   = (XOSC_START_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNTH_SETTLE_CYC = 16;
  localparam int CAL_CYC          = 64;
  localparam int BYTE_CYC         = 320;
  localparam int RECAL_IDLE_CYC   = 100000;
  localparam int CNT_W            = 16;
  // ============================================================
  // buffering and protocol
  localparam int       BUF_DEPTH = 32;
  localparam int       MAX_RETRY = 3;
  localparam bit [7:0] ACK_CODE  = 8'ha5;
  // ============================================================
  // commands from host, modes of the device (sleep is the reset mode)
  typedef enum logic [2:0] {
    cmd_wake, synth_wakeup_cmd, cmd_calibrate, cmd_tx, cmd_rx, cmd_idle, cmd_sleep, cmd_flush
  } cmd_type;
  typedef enum logic [2:0] {
    mode_sleep, mode_xosc, mode_idle, mode_synth_start, mode_synth_on, mode_cal, mode_tx, mode_rx
  } mode_type;
endpackage

// [radio_link_if.sv]
// link between the radio mode sequencer and its host driver
`timescale 1ns/1ps
`default_nettype none
interface radio_link_if;
  radio_seq_pkg::cmd_type  cmd;
  logic                    cmd_valid;
  logic                    wr_valid;
  logic [7:0]              wr_data;
  radio_seq_pkg::mode_type mode;
  logic                    ready;
  logic                    tx_done;
  logic                    rx_valid;
  logic [7:0]              rx_data;
  logic                    rx_last;

  modport device (input cmd, cmd_valid, wr_valid, wr_data,
                  output mode, ready, tx_done, rx_valid, rx_data, rx_last);
  modport host   (output cmd, cmd_valid, wr_valid, wr_data,
                  input mode, ready, tx_done, rx_valid, rx_data, rx_last);
endinterface
`default_nettype wire

// [radio_mode_dev.sv]
// device end: operating-mode sequencer with transmit buffer
`timescale 1ns/1ps
`default_nettype none
module radio_mode_dev #(
  parameter int BUF_DEPTH = radio_seq_pkg::BUF_DEPTH,
  parameter int XOSC_CYC  = radio_seq_pkg::XOSC_START_CYC,
  parameter int SYNTH_CYC = radio_seq_pkg::SYNTH_SETTLE_CYC,
  parameter int CAL_CYC   = radio_seq_pkg::CAL_CYC,
  parameter int BYTE_CYC  = radio_seq_pkg::BYTE_CYC
) (
  input  wire logic      i_core_clk,
  input  wire logic      i_rst_b,
  radio_link_if.device   link,
  output logic           o_tx_valid,
  output logic [7:0]     o_tx_data,
  input  wire logic      i_rx_valid,
  input  wire logic [7:0] i_rx_data,
  input  wire logic      i_rx_last
);
  localparam int AW = $clog2(BUF_DEPTH);
  localparam int LW = $clog2(BUF_DEPTH + 1);
  localparam int CW = radio_seq_pkg::CNT_W;

  if (BUF_DEPTH < 2 || XOSC_CYC < 1 || SYNTH_CYC < 1 || CAL_CYC < 1 || BYTE_CYC < 1 ||
      XOSC_CYC > 2**CW || SYNTH_CYC > 2**CW || CAL_CYC > 2**CW || BYTE_CYC > 2**CW) begin : g_bad
    $error("radio_mode_dev: parameter out of range");
  end

  radio_seq_pkg::mode_type mode_reg, mode_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [LW-1:0] len_reg, len_next;
  logic [LW-1:0] rd_reg, rd_next;
  logic          rdy_reg, rdy_next;
  logic          done_reg, done_next;
  logic          txv_reg, txv_next;
  logic [7:0]    txd_reg, txd_next;
  logic          rxv_reg, rxv_next;
  logic [7:0]    rxd_reg, rxd_next;
  logic          rxl_reg, rxl_next;
  logic [7:0]    mem [BUF_DEPTH];
  logic          cmd_on, buf_wr;

  // ============================================================
  // mode sequencing
  always_comb begin
    mode_next = mode_reg;
    cnt_next  = cnt_reg;
    len_next  = len_reg;
    rd_next   = rd_reg;
    done_next = 1'b0;
    txv_next  = 1'b0;
    txd_next  = txd_reg;
    rxv_next  = 1'b0;
    rxd_next  = rxd_reg;
    rxl_next  = 1'b0;
    cmd_on    = link.cmd_valid;
    // buffer refuses bytes while asleep, starting up, sending, or full
    buf_wr    = link.wr_valid && (len_reg < LW'(BUF_DEPTH)) &&
                (mode_reg != radio_seq_pkg::mode_sleep) &&
                (mode_reg != radio_seq_pkg::mode_xosc) && (mode_reg != radio_seq_pkg::mode_tx);
    if (buf_wr) begin
      len_next = len_reg + LW'(1);
    end
    case (mode_reg)
      radio_seq_pkg::mode_sleep: begin
        if (cmd_on && link.cmd == radio_seq_pkg::cmd_wake) begin
          mode_next = radio_seq_pkg::mode_xosc;
          cnt_next  = '0;
        end
      end
      radio_seq_pkg::mode_xosc: begin
        if (cnt_reg == CW'(XOSC_CYC - 1)) begin
          mode_next = radio_seq_pkg::mode_idle;
        end else begin
          cnt_next = cnt_reg + CW'(1);
        end
      end
      radio_seq_pkg::mode_idle: begin
        if (cmd_on && link.cmd == radio_seq_pkg::synth_wakeup_cmd) begin
          mode_next = radio_seq_pkg::mode_synth_start;
          cnt_next  = '0;
        end else if (cmd_on && link.cmd == radio_seq_pkg::cmd_sleep) begin
          mode_next = radio_seq_pkg::mode_sleep;
        end else if (cmd_on && link.cmd == radio_seq_pkg::cmd_flush) begin
          len_next = '0;
        end
      end
      radio_seq_pkg::mode_synth_start: begin
        if (cnt_reg == CW'(SYNTH_CYC - 1)) begin
          mode_next = radio_seq_pkg::mode_synth_on;
        end else begin
          cnt_next = cnt_reg + CW'(1);
        end
      end
      radio_seq_pkg::mode_synth_on: begin
        cnt_next = '0;
        rd_next  = '0;
        // transmit with an empty buffer would send nothing; it is ignored
        if (cmd_on && link.cmd == radio_seq_pkg::cmd_tx && len_reg != '0) begin
          mode_next = radio_seq_pkg::mode_tx;
        end else if (cmd_on && link.cmd == radio_seq_pkg::cmd_rx) begin
          mode_next = radio_seq_pkg::mode_rx;
        end else if (cmd_on && link.cmd == radio_seq_pkg::cmd_calibrate) begin
          mode_next = radio_seq_pkg::mode_cal;
        end else if (cmd_on && link.cmd == radio_seq_pkg::cmd_idle) begin
          mode_next = radio_seq_pkg::mode_idle;
        end else if (cmd_on && link.cmd == radio_seq_pkg::cmd_sleep) begin
          mode_next = radio_seq_pkg::mode_sleep;
        end
      end
      radio_seq_pkg::mode_cal: begin
        if (cnt_reg == CW'(CAL_CYC - 1)) begin
          mode_next = radio_seq_pkg::mode_synth_on;
        end else begin
          cnt_next = cnt_reg + CW'(1);
        end
      end
      radio_seq_pkg::mode_tx: begin
        // one byte per byte period, frame kept for a retransmit
        if (cmd_on && link.cmd == radio_seq_pkg::cmd_idle) begin
          mode_next = radio_seq_pkg::mode_idle;
        end else if (cnt_reg == CW'(BYTE_CYC - 1)) begin
          cnt_next = '0;
          txv_next = 1'b1;
          txd_next = mem[rd_reg[AW-1:0]];
          if (rd_reg == len_reg - LW'(1)) begin
            mode_next = radio_seq_pkg::mode_idle;
            done_next = 1'b1;
          end else begin
            rd_next = rd_reg + LW'(1);
          end
        end else begin
          cnt_next = cnt_reg + CW'(1);
        end
      end
      radio_seq_pkg::mode_rx: begin
        if (i_rx_valid) begin
          rxv_next = 1'b1;
          rxd_next = i_rx_data;
          rxl_next = i_rx_last;
          if (i_rx_last) begin
            mode_next = radio_seq_pkg::mode_idle;
          end
        end else if (cmd_on && link.cmd == radio_seq_pkg::cmd_idle) begin
          mode_next = radio_seq_pkg::mode_idle;
        end
      end
      default: mode_next = radio_seq_pkg::mode_sleep;
    endcase
    // host interface stays dark until the oscillator has started
    rdy_next = (mode_next != radio_seq_pkg::mode_sleep) &&
               (mode_next != radio_seq_pkg::mode_xosc);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_reg <= radio_seq_pkg::mode_sleep;
      cnt_reg  <= '0;
      len_reg  <= '0;
      rd_reg   <= '0;
      rdy_reg  <= 1'b0;
      done_reg <= 1'b0;
      txv_reg  <= 1'b0;
      txd_reg  <= 8'h00;
      rxv_reg  <= 1'b0;
      rxd_reg  <= 8'h00;
      rxl_reg  <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      cnt_reg  <= cnt_next;
      len_reg  <= len_next;
      rd_reg   <= rd_next;
      rdy_reg  <= rdy_next;
      done_reg <= done_next;
      txv_reg  <= txv_next;
      txd_reg  <= txd_next;
      rxv_reg  <= rxv_next;
      rxd_reg  <= rxd_next;
      rxl_reg  <= rxl_next;
    end
  end

  // ============================================================
  // transmit buffer storage, data only, no reset needed
  always_ff @(posedge i_core_clk) begin
    if (buf_wr) begin
      mem[len_reg[AW-1:0]] <= link.wr_data;
    end
  end

  assign link.mode     = mode_reg;
  assign link.ready    = rdy_reg;
  assign link.tx_done  = done_reg;
  assign link.rx_valid = rxv_reg;
  assign link.rx_data  = rxd_reg;
  assign link.rx_last  = rxl_reg;
  assign o_tx_valid    = txv_reg;
  assign o_tx_data     = txd_reg;
endmodule
`default_nettype wire

// [radio_mode_host.sv]
// host end: drives wake, load, transmit, acknowledge wait and retry
`timescale 1ns/1ps
`default_nettype none
module radio_mode_host #(
  parameter int       RECAL_CYC = radio_seq_pkg::RECAL_IDLE_CYC,
  parameter int       MAX_RETRY = radio_seq_pkg::MAX_RETRY,
  parameter bit [7:0] ACK_CODE  = radio_seq_pkg::ACK_CODE
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  radio_link_if.host       link,
  input  wire logic        i_start,
  input  wire logic [7:0]  i_frame_count,
  input  wire logic [15:0] i_ack_timeout,
  input  wire logic        i_frame_valid,
  input  wire logic [7:0]  i_frame_data,
  input  wire logic        i_frame_last,
  output logic             o_frame_ready,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_fail
);
  localparam int RW = 4;
  localparam int IW = 32;

  if (MAX_RETRY < 0 || MAX_RETRY >= 2**RW || RECAL_CYC < 1) begin : g_bad
    $error("radio_mode_host: parameter out of range");
  end

  typedef enum logic [2:0] {
    s_off, s_wake, s_load, s_start, s_synth, s_tx, s_rx
  } state_type;

  state_type               state_reg, state_next;
  radio_seq_pkg::cmd_type  cmd_reg, cmd_next;
  logic                    cmdv_reg, cmdv_next;
  logic                    wrv_reg, wrv_next;
  logic [7:0]              wrd_reg, wrd_next;
  logic                    settle_reg, settle_next;
  logic                    go_rx_reg, go_rx_next;
  logic                    cal_due_reg, cal_due_next;
  logic [IW-1:0]           idle_cnt_reg, idle_cnt_next;
  logic [15:0]             tmo_reg, tmo_next;
  logic                    first_reg, first_next;
  logic                    ack_reg, ack_next;
  logic [7:0]              left_reg, left_next;
  logic [RW-1:0]           retry_reg, retry_next;
  logic                    rdy_reg, rdy_next;
  logic                    done_reg, done_next;
  logic                    fail_reg, fail_next;
  logic                    busy_reg, busy_next;
  logic                    ack_ok, retry_now;

  // ============================================================
  // session sequencing
  always_comb begin
    state_next    = state_reg;
    cmd_next      = cmd_reg;
    cmdv_next     = 1'b0;
    wrv_next      = 1'b0;
    wrd_next      = wrd_reg;
    settle_next   = 1'b0;
    go_rx_next    = go_rx_reg;
    cal_due_next  = cal_due_reg;
    idle_cnt_next = idle_cnt_reg;
    tmo_next      = tmo_reg;
    first_next    = first_reg;
    ack_next      = ack_reg;
    left_next     = left_reg;
    retry_next    = retry_reg;
    done_next     = 1'b0;
    fail_next     = 1'b0;
    retry_now     = 1'b0;
    // first byte of the answer decides; a later byte cannot change it
    ack_ok        = first_reg ? (link.rx_data == ACK_CODE) : ack_reg;

    // loop drifts while idle, so a long gap forces a fresh calibration
    if (state_reg != s_off) begin
      if (idle_cnt_reg >= IW'(RECAL_CYC - 1)) begin
        cal_due_next = 1'b1;
      end else begin
        idle_cnt_next = idle_cnt_reg + IW'(1);
      end
    end

    case (state_reg)
      s_off: begin
        if (i_start && i_frame_count != 8'h00) begin
          cmd_next     = radio_seq_pkg::cmd_wake;
          cmdv_next    = 1'b1;
          left_next    = i_frame_count;
          retry_next   = '0;
          cal_due_next = 1'b1;
          settle_next  = 1'b1;
          state_next   = s_wake;
        end
      end
      s_wake: begin
        // device ignores the link until its oscillator is running
        if (!settle_reg && link.ready) begin
          cmd_next   = radio_seq_pkg::cmd_flush;
          cmdv_next  = 1'b1;
          state_next = s_load;
        end
      end
      s_load: begin
        if (i_frame_valid && rdy_reg) begin
          wrv_next = 1'b1;
          wrd_next = i_frame_data;
          if (i_frame_last) begin
            retry_next = '0;
            state_next = s_start;
          end
        end
      end
      s_start: begin
        cmd_next    = radio_seq_pkg::synth_wakeup_cmd;
        cmdv_next   = 1'b1;
        settle_next = 1'b1;
        state_next  = s_synth;
      end
      s_synth: begin
        if (!settle_reg && link.mode == radio_seq_pkg::mode_synth_on) begin
          cmdv_next   = 1'b1;
          settle_next = 1'b1;
          if (cal_due_reg) begin
            cmd_next      = radio_seq_pkg::cmd_calibrate;
            cal_due_next  = 1'b0;
            idle_cnt_next = '0;
          end else if (go_rx_reg) begin
            cmd_next   = radio_seq_pkg::cmd_rx;
            tmo_next   = 16'h0000;
            first_next = 1'b1;
            ack_next   = 1'b0;
            state_next = s_rx;
          end else begin
            cmd_next   = radio_seq_pkg::cmd_tx;
            state_next = s_tx;
          end
        end
      end
      s_tx: begin
        if (link.tx_done) begin
          go_rx_next = 1'b1;
          state_next = s_start;
        end
      end
      s_rx: begin
        if (link.rx_valid) begin
          first_next = 1'b0;
          ack_next   = ack_ok;
        end
        // a frame that ends in the timeout cycle still counts
        if (link.rx_valid && link.rx_last) begin
          go_rx_next = 1'b0;
          if (!ack_ok) begin
            retry_now = 1'b1;
          end else if (left_reg == 8'h01) begin
            cmd_next   = radio_seq_pkg::cmd_sleep;
            cmdv_next  = 1'b1;
            done_next  = 1'b1;
            state_next = s_off;
          end else begin
            left_next  = left_reg - 8'h01;
            cmd_next   = radio_seq_pkg::cmd_flush;
            cmdv_next  = 1'b1;
            state_next = s_load;
          end
        end else if (tmo_reg == i_ack_timeout) begin
          cmd_next   = radio_seq_pkg::cmd_idle;
          cmdv_next  = 1'b1;
          go_rx_next = 1'b0;
          retry_now  = 1'b1;
        end else begin
          tmo_next = tmo_reg + 16'h0001;
        end
        // frame stays in the device buffer, so a retry needs no reload
        if (retry_now) begin
          if (retry_reg == RW'(MAX_RETRY)) begin
            fail_next  = 1'b1;
            state_next = s_off;
          end else begin
            retry_next = retry_reg + RW'(1);
            state_next = s_start;
          end
        end
      end
      default: state_next = s_off;
    endcase
    // the device may still need a sleep command after a failed session
    if (state_reg == s_start && retry_reg == '0 && fail_reg) begin
      state_next = s_off;
    end
    rdy_next = (state_next == s_load) && !(state_reg == s_load && i_frame_valid && i_frame_last);
    busy_next = (state_next != s_off);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg    <= s_off;
      cmd_reg      <= radio_seq_pkg::cmd_sleep;
      cmdv_reg     <= 1'b0;
      wrv_reg      <= 1'b0;
      wrd_reg      <= 8'h00;
      settle_reg   <= 1'b0;
      go_rx_reg    <= 1'b0;
      cal_due_reg  <= 1'b1;
      idle_cnt_reg <= '0;
      tmo_reg      <= 16'h0000;
      first_reg    <= 1'b0;
      ack_reg      <= 1'b0;
      left_reg     <= 8'h00;
      retry_reg    <= '0;
      rdy_reg      <= 1'b0;
      done_reg     <= 1'b0;
      fail_reg     <= 1'b0;
      busy_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cmd_reg      <= cmd_next;
      cmdv_reg     <= cmdv_next;
      wrv_reg      <= wrv_next;
      wrd_reg      <= wrd_next;
      settle_reg   <= settle_next;
      go_rx_reg    <= go_rx_next;
      cal_due_reg  <= cal_due_next;
      idle_cnt_reg <= idle_cnt_next;
      tmo_reg      <= tmo_next;
      first_reg    <= first_next;
      ack_reg      <= ack_next;
      left_reg     <= left_next;
      retry_reg    <= retry_next;
      rdy_reg      <= rdy_next;
      done_reg     <= done_next;
      fail_reg     <= fail_next;
      busy_reg     <= busy_next;
    end
  end

  // ============================================================
  // outputs straight from registers
  assign link.cmd       = cmd_reg;
  assign link.cmd_valid = cmdv_reg;
  assign link.wr_valid  = wrv_reg;
  assign link.wr_data   = wrd_reg;
  assign o_frame_ready  = rdy_reg;
  assign o_busy         = busy_reg;
  assign o_done         = done_reg;
  assign o_fail         = fail_reg;
endmodule
`default_nettype wire

// [radio_link_chk.sv]
// link assertions for the mode sequencer facing its host driver
`timescale 1ns/1ps
`default_nettype none
module radio_link_chk (
  input wire logic                    i_core_clk,
  input wire logic                    i_rst_b,
  input wire radio_seq_pkg::cmd_type  cmd,
  input wire logic                    cmd_valid,
  input wire logic                    wr_valid,
  input wire logic [7:0]              wr_data,
  input wire radio_seq_pkg::mode_type mode,
  input wire logic                    ready,
  input wire logic                    tx_done,
  input wire logic                    rx_valid,
  input wire logic [7:0]              rx_data,
  input wire logic                    rx_last
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // ============================================================
  // wake: counts fixed at the bench's short oscillator start of 8
  wake_to_xosc_a: assert property (
    mode == radio_seq_pkg::mode_sleep && cmd_valid && cmd == radio_seq_pkg::cmd_wake
    |=> mode == radio_seq_pkg::mode_xosc) else $error("wake did not start oscillator");
  xosc_exit_a: assert property (
    mode == radio_seq_pkg::mode_xosc
    |=> mode inside {radio_seq_pkg::mode_xosc, radio_seq_pkg::mode_idle})
    else $error("oscillator start left to an active mode");
  xosc_time_a: assert property (
    $rose(mode == radio_seq_pkg::mode_xosc) |-> (mode == radio_seq_pkg::mode_xosc)[*8]
    ##1 mode == radio_seq_pkg::mode_idle) else $error("oscillator start length wrong");
  ready_mode_a: assert property (
    ready == (mode != radio_seq_pkg::mode_sleep && mode != radio_seq_pkg::mode_xosc))
    else $error("ready does not follow mode");
  // ============================================================
  // synthesizer, calibration and transfers
  synth_time_a: assert property (
    $rose(mode == radio_seq_pkg::mode_synth_start)
    |-> (mode == radio_seq_pkg::mode_synth_start)[*4] ##1 mode == radio_seq_pkg::mode_synth_on)
    else $error("synthesizer settle length wrong");
  tx_entry_a: assert property (
    $rose(mode == radio_seq_pkg::mode_tx) |-> $past(mode) == radio_seq_pkg::mode_synth_on)
    else $error("transmit entered without synthesizer");
  cal_time_a: assert property (
    $rose(mode == radio_seq_pkg::mode_cal) |-> $past(mode) == radio_seq_pkg::mode_synth_on
    ##0 (mode == radio_seq_pkg::mode_cal)[*4] ##1 mode == radio_seq_pkg::mode_synth_on)
    else $error("calibration entry or length wrong");
  tx_done_idle_a: assert property (
    tx_done |-> mode == radio_seq_pkg::mode_idle && $past(mode) == radio_seq_pkg::mode_tx)
    else $error("transmit end not back in idle");
  tx_exit_a: assert property (
    mode == radio_seq_pkg::mode_tx ##1 mode != radio_seq_pkg::mode_tx
    |-> mode == radio_seq_pkg::mode_idle) else $error("transmit left to non idle mode");
  rx_end_a: assert property (
    rx_valid && rx_last |-> mode == radio_seq_pkg::mode_idle)
    else $error("receive did not end after one frame");
  rx_src_a: assert property (
    rx_valid |-> $past(mode) == radio_seq_pkg::mode_rx) else $error("byte outside receive");
endmodule
`default_nettype wire

// [radio_mode_sequencer_tb.sv]
// bench: host and sequencer joined, plus a bare sequencer driven by hand
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module radio_mode_sequencer_tb;
  logic        i_core_clk = 1'b0;
  logic        i_rst_b    = 1'b0;
  logic        start      = 1'b0;
  logic [7:0]  fcount     = 8'h00;
  logic [15:0] ack_to     = 16'h0000;
  logic        fvalid     = 1'b0;
  logic [7:0]  fdata      = 8'h00;
  logic        flast      = 1'b0;
  logic        frame_ready, busy, done, fail, tx_valid;
  logic [7:0]  tx_data;
  logic        rxv = 1'b0;
  logic [7:0]  rxd = 8'h00;
  logic        rxl = 1'b0;
  logic        answered = 1'b0;
  logic [7:0]  resp_q[$];
  logic [7:0]  sent_q[$];
  int          n_tx_done, n_rx_cyc, n_errors, total_checks, cyc;
  radio_link_if lnk ();
  radio_link_if lnk2 ();
  always #50 i_core_clk = ~i_core_clk;
  radio_mode_dev #(.XOSC_CYC(8), .SYNTH_CYC(4), .CAL_CYC(4), .BYTE_CYC(2)) radio_mode_dev_i (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .link(lnk), .o_tx_valid(tx_valid),
    .o_tx_data(tx_data), .i_rx_valid(rxv), .i_rx_data(rxd), .i_rx_last(rxl));
  radio_mode_host #(.RECAL_CYC(50)) radio_mode_host_i (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .link(lnk), .i_start(start),
    .i_frame_count(fcount), .i_ack_timeout(ack_to), .i_frame_valid(fvalid),
    .i_frame_data(fdata), .i_frame_last(flast), .o_frame_ready(frame_ready),
    .o_busy(busy), .o_done(done), .o_fail(fail));
  // bare sequencer at full default timing: the bench plays a host that breaks the ordering
  radio_mode_dev radio_mode_dev_i2 (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .link(lnk2), .o_tx_valid(),
    .o_tx_data(), .i_rx_valid(rxv), .i_rx_data(rxd), .i_rx_last(rxl));
  radio_link_chk radio_link_chk_i (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .cmd(lnk.cmd), .cmd_valid(lnk.cmd_valid),
    .wr_valid(lnk.wr_valid), .wr_data(lnk.wr_data), .mode(lnk.mode), .ready(lnk.ready),
    .tx_done(lnk.tx_done), .rx_valid(lnk.rx_valid), .rx_data(lnk.rx_data),
    .rx_last(lnk.rx_last));
  // ============================================================
  // far radio: one queued byte per receive window, silence when the queue is empty
  always @(negedge i_core_clk) begin
    rxv = 1'b0;
    rxl = 1'b0;
    rxd = ~rxd;  // released data lines wander, never hold the last byte
    if (lnk.mode != radio_seq_pkg::mode_rx) begin
      answered = 1'b0;
    end else if (!answered && resp_q.size() != 0) begin
      rxd = resp_q.pop_front();
      rxv = 1'b1;
      rxl = 1'b1;
      answered = 1'b1;
    end
  end
  // air monitor, read mid-cycle where the registered outputs have settled
  always @(negedge i_core_clk) begin
    if (tx_valid) sent_q.push_back(tx_data);
    if (lnk.tx_done) n_tx_done++;
    if (lnk.mode == radio_seq_pkg::mode_rx) n_rx_cyc++;
  end
  // hang guard: sessions here need a few thousand cycles at most
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      test_done();
    end
  end
  function automatic logic [7:0] fbyte(input int f, input int j);
    return 8'(f * 16 + j + 1);
  endfunction
  task automatic test_done();
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ============================================================
  // one host session of three-byte frames, then verdict on air traffic
  task automatic session(input int nf, input logic [15:0] tmo, input int ntx, input logic ok);
    int   f, j, n;
    logic tk;
    sent_q.delete();
    n_tx_done = 0;
    n_rx_cyc = 0;
    fcount = 8'(nf);
    ack_to = tmo;
    start = 1'b1;
    @(negedge i_core_clk);
    start = 1'b0;
    `CHK("busy at start", 1'b1, busy)
    for (f = 0; f < nf; f++) begin
      for (j = 0; j < 3; j++) begin
        fvalid = 1'b1;
        fdata = fbyte(f, j);
        flast = (j == 2);
        tk = 1'b0;
        while (!tk) begin
          tk = frame_ready; // host takes the byte at the coming edge
          @(negedge i_core_clk);
        end
      end
    end
    fvalid = 1'b0;
    flast = 1'b0;
    for (n = 0; n < 5000 && !(done || fail); n++) @(negedge i_core_clk);
    `CHK("done", ok, done)
    `CHK("fail", !ok, fail)
    `CHK("transmissions", ntx, n_tx_done)
    `CHK("bytes sent", 3 * ntx, sent_q.size())
    `CHK("busy at end", 1'b0, busy)
    for (n = 0; n < sent_q.size(); n++)
      `CHK("air byte", fbyte(nf == 1 ? 0 : n / 3, n % 3), sent_q[n])
    repeat (4) @(negedge i_core_clk);
    `CHK("end mode", ok ? radio_seq_pkg::mode_sleep : radio_seq_pkg::mode_idle, lnk.mode)
  endtask
  // single command on the bare sequencer, one quiet cycle so valid never re-rises at once
  task automatic cmd2(input radio_seq_pkg::cmd_type c, input int wt);
    lnk2.cmd = c;
    lnk2.cmd_valid = 1'b1;
    @(negedge i_core_clk);
    lnk2.cmd_valid = 1'b0;
    repeat (wt + 1) @(negedge i_core_clk);
  endtask
  // ============================================================
  // main sequence
  initial begin
    lnk2.cmd = radio_seq_pkg::cmd_idle;
    lnk2.cmd_valid = 1'b0;
    lnk2.wr_valid = 1'b0;
    lnk2.wr_data = 8'h00;
    repeat (16) @(negedge i_core_clk);
    i_rst_b = 1'b1;
    @(negedge i_core_clk);
    cmd2(radio_seq_pkg::cmd_tx, 0);
    `CHK("tx from sleep", radio_seq_pkg::mode_sleep, lnk2.mode)
    cmd2(radio_seq_pkg::cmd_wake, radio_seq_pkg::XOSC_START_CYC);
    `CHK("woken mode", radio_seq_pkg::mode_idle, lnk2.mode)
    `CHK("ready", 1'b1, lnk2.ready)
    cmd2(radio_seq_pkg::cmd_tx, 0);
    `CHK("tx from idle", radio_seq_pkg::mode_idle, lnk2.mode)
    cmd2(radio_seq_pkg::cmd_calibrate, 0);
    `CHK("cal from idle", radio_seq_pkg::mode_idle, lnk2.mode)
    cmd2(radio_seq_pkg::synth_wakeup_cmd, radio_seq_pkg::SYNTH_SETTLE_CYC);
    `CHK("synth on", radio_seq_pkg::mode_synth_on, lnk2.mode)
    cmd2(radio_seq_pkg::cmd_tx, 0);
    `CHK("tx empty", radio_seq_pkg::mode_synth_on, lnk2.mode)
    cmd2(radio_seq_pkg::cmd_calibrate, radio_seq_pkg::CAL_CYC);
    `CHK("after cal", radio_seq_pkg::mode_synth_on, lnk2.mode)
    resp_q = '{8'ha5, 8'ha5};
    session(2, 16'h0030, 2, 1'b1);
    resp_q = '{8'h00, 8'h5a, 8'ha5};
    session(1, 16'h0030, 3, 1'b1);
    resp_q.delete();
    session(1, 16'h0020, 1 + radio_seq_pkg::MAX_RETRY, 1'b0);
    // each silent window lasts the timeout plus the cycle in which idle is issued
    `CHK("rx window", (1 + radio_seq_pkg::MAX_RETRY) * (16'h0020 + 1), n_rx_cyc)
    test_done();
  end
endmodule
`default_nettype wire
